/* common/cie_cfg.svh */
// Purpose: Constants of the instruction execution core
// Assumes: Included by its bare name
// Notes:   Flag positions follow the status flags register layout
`ifndef CIE_CFG_SVH
`define CIE_CFG_SVH
`define CIE_FLAG_C 0
`define CIE_FLAG_Z 1
`define CIE_FLAG_N 2
`define CIE_FLAG_V 3
`define CIE_FLAG_S 4
`define CIE_FLAG_H 5
`define CIE_FLAG_T 6
`define CIE_FLAG_I 7
`define CIE_RST_FLAGS 8'h00
`define CIE_RST_PC 16'h0000
`define CIE_RST_SP 16'h10ff
`define CIE_PTR_X 5'h1a
`define CIE_PTR_Y 5'h1c
`define CIE_PTR_Z 5'h1e
`define CIE_CYC_BR_TAKEN 2
`define CIE_CYC_DMEM 2
`define CIE_CYC_PMEM 3
`define CIE_CYC_IO 2
`endif

/* common/cie_pkg.sv */
// Purpose: Types of the instruction execution core
// Assumes: Instructions arrive already decoded
// Notes:   Unused operation codes execute as no-operation
`default_nettype none
package cie_pkg;
  typedef enum logic [5:0] {
    op_nop, op_sleep, op_watchdog_kick, op_break,
    op_branch_carry_set, op_branch_carry_clear, op_branch_same_higher, op_branch_lower,
    op_branch_negative, op_branch_positive, op_branch_signed_ge, op_branch_signed_lt,
    op_branch_halfcarry_set, op_branch_halfcarry_clear, op_branch_tbit_set,
    op_branch_tbit_clear, op_branch_overflow_set, op_branch_overflow_clear,
    op_branch_irq_enabled, op_branch_irq_disabled,
    op_register_move, op_register_pair_copy, op_load_immediate,
    op_load_indirect, op_load_displaced, op_load_direct,
    op_store_indirect, op_store_displaced, op_store_direct,
    op_program_memory_read, op_extended_program_read, op_push, op_pop,
    op_io_bit_set, op_io_bit_clear,
    op_logical_left_shift, op_logical_right_shift, op_rotate_left_carry,
    op_rotate_right_carry, op_arithmetic_right_shift, op_nibble_swap,
    op_bit_to_tflag, op_tflag_to_bit, op_status_flag_set, op_status_flag_clear
  } cie_op_t;
  typedef enum logic [1:0] {cie_ptr_x, cie_ptr_y, cie_ptr_z} cie_ptr_t;
  typedef enum logic [1:0] {cie_pm_plain, cie_pm_post_inc, cie_pm_pre_dec} cie_pmode_t;
  typedef struct packed {
    cie_op_t    op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [2:0] bsel;
    cie_ptr_t   ptr;
    cie_pmode_t pmode;
    logic       no_operand;
    logic [7:0] imm;
    logic [6:0] k;
    logic [15:0] addr;
  } cie_instr_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } cie_dmem_req_t;
  typedef struct packed {
    logic [4:0] addr;
    logic [2:0] bsel;
    logic       value;
    logic       strobe;
  } cie_io_req_t;
  typedef enum logic [1:0] {cie_st_run, cie_st_wait, cie_st_halt} cie_state_t;
  typedef enum logic [1:0] {cie_wb_none, cie_wb_dmem, cie_wb_pmem} cie_wb_t;
endpackage
`default_nettype wire

/* logic/cie_core.sv */
// Purpose: Executes decoded instructions of an 8-bit core
// Assumes: Data memory answers in the cycle it is asked
// Notes:   Program memory answers one cycle after its strobe
// Notes on behaviour
// - Carry branches jump pc plus offset plus one
// - Signed branches test negative xor overflow
// - Negative flag branches keep all flags
// - Halfcarry branches cost one or two cycles
// - Transfer bit branches jump to offset target
// - Overflow and interrupt enable branches likewise
// - Moves and immediate load: one cycle, flags kept
// - Indirect loads two cycles, post inc, pre dec
// - Displaced loads use second or third pointer
// - Indirect stores mirror the load forms
// - Direct accesses use embedded address, two cycles
// - Program read via third pointer, three cycles
// - Extended read prepends page, increments whole value
// - Push and pop take two cycles
// - I/O bit set or clear, two cycles
// - Rotates pass through carry, update four flags
// - Transfer flag to and from register bit
// - Flag set and clear force chosen flag
// - Break halts for debug, others one cycle
`include "cie_cfg.svh"
`default_nettype none
module cie_core (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  // Instruction issue
  input  wire logic                   instr_valid,
  input  wire cie_pkg::cie_instr_t    instr,
  output logic                        instr_ready,
  // Data memory
  output cie_pkg::cie_dmem_req_t      dmem_req,
  input  wire logic [7:0]             dmem_rdata,
  // Program memory
  output logic [23:0]                 pmem_addr,
  output logic                        pmem_re,
  input  wire logic [7:0]             pmem_rdata,
  // Page extension register in I/O space
  input  wire logic [7:0]             page_ext,
  output logic                        page_ext_we,
  output logic [7:0]                  page_ext_wdata,
  // I/O bit requests and control pulses
  output cie_pkg::cie_io_req_t        io_req,
  output logic                        sleep_pulse,
  output logic                        watchdog_kick_pulse,
  output logic                        halted,
  input  wire logic                   dbg_resume,
  // Observation
  input  wire logic [4:0]             dbg_raddr,
  output logic [7:0]                  dbg_rdata,
  output logic [15:0]                 pc,
  output logic [15:0]                 sp,
  output logic [7:0]                  status_flags
);
  cie_pkg::cie_state_t    st_r, st_nxt;
  cie_pkg::cie_wb_t       wbk_r, wbk_nxt;
  cie_pkg::cie_dmem_req_t dreq_r, dreq_nxt;
  cie_pkg::cie_io_req_t   io_r, io_nxt;
  logic [1:0]  cnt_r, cnt_nxt;
  logic [4:0]  wbr_r, wbr_nxt;
  logic [15:0] pc_r, pc_nxt, sp_r, sp_nxt;
  logic [7:0]  flg_r, flg_nxt, dbg_r, dbg_nxt, pwd_r, pwd_nxt;
  logic [23:0] pa_r, pa_nxt, zext;
  logic        pre_r, pre_nxt, pwe_r, pwe_nxt, slp_r, slp_nxt, wdk_r, wdk_nxt;
  logic [7:0]  rf_r [32];
  logic [7:0]  rf_nxt [32];
  logic [7:0]  opd, rrv, sres;
  logic [4:0]  pidx;
  logic [15:0] pv, ea, np, zv, br_tgt;
  logic        is_br, br_ok, scar, acc, is_disp;

  assign acc    = instr_valid && instr_ready;
  assign opd    = rf_r[instr.rd];
  assign rrv    = rf_r[instr.rr];
  assign zv     = {rf_r[`CIE_PTR_Z | 5'h01], rf_r[`CIE_PTR_Z]};
  assign zext   = {page_ext, zv};
  assign br_tgt = pc_r + {{9{instr.k[6]}}, instr.k} + 16'h0001;
  assign is_disp = instr.op == cie_pkg::op_load_displaced ||
                   instr.op == cie_pkg::op_store_displaced;

  // Pointer pair, effective address and updated pointer
  always_comb
  begin
    unique case (instr.ptr)
      cie_pkg::cie_ptr_y: pidx = `CIE_PTR_Y;
      cie_pkg::cie_ptr_z: pidx = `CIE_PTR_Z;
      default:            pidx = `CIE_PTR_X;
    endcase
    pv = {rf_r[pidx | 5'h01], rf_r[pidx]};
    np = pv;
    ea = pv;
    if (is_disp)
      ea = pv + {10'h000, instr.imm[5:0]};
    else if (instr.pmode == cie_pkg::cie_pm_pre_dec)
    begin
      ea = pv - 16'h0001;
      np = ea;
    end
    else if (instr.pmode == cie_pkg::cie_pm_post_inc)
      np = pv + 16'h0001;
  end

  // Branch condition and shift result
  always_comb
  begin
    is_br = 1'b1;
    br_ok = 1'b0;
    sres  = opd;
    scar  = flg_r[`CIE_FLAG_C];
    unique case (instr.op)
      cie_pkg::op_branch_carry_set,
      cie_pkg::op_branch_lower:          br_ok = flg_r[`CIE_FLAG_C];
      cie_pkg::op_branch_carry_clear,
      cie_pkg::op_branch_same_higher:    br_ok = !flg_r[`CIE_FLAG_C];
      cie_pkg::op_branch_negative:       br_ok = flg_r[`CIE_FLAG_N];
      cie_pkg::op_branch_positive:       br_ok = !flg_r[`CIE_FLAG_N];
      cie_pkg::op_branch_signed_ge:
        br_ok = !(flg_r[`CIE_FLAG_N] ^ flg_r[`CIE_FLAG_V]);
      cie_pkg::op_branch_signed_lt:
        br_ok = flg_r[`CIE_FLAG_N] ^ flg_r[`CIE_FLAG_V];
      cie_pkg::op_branch_halfcarry_set:  br_ok = flg_r[`CIE_FLAG_H];
      cie_pkg::op_branch_halfcarry_clear: br_ok = !flg_r[`CIE_FLAG_H];
      cie_pkg::op_branch_tbit_set:       br_ok = flg_r[`CIE_FLAG_T];
      cie_pkg::op_branch_tbit_clear:     br_ok = !flg_r[`CIE_FLAG_T];
      cie_pkg::op_branch_overflow_set:   br_ok = flg_r[`CIE_FLAG_V];
      cie_pkg::op_branch_overflow_clear: br_ok = !flg_r[`CIE_FLAG_V];
      cie_pkg::op_branch_irq_enabled:    br_ok = flg_r[`CIE_FLAG_I];
      cie_pkg::op_branch_irq_disabled:   br_ok = !flg_r[`CIE_FLAG_I];
      default:
      begin
        is_br = 1'b0;
        unique case (instr.op)
          cie_pkg::op_logical_left_shift:  {scar, sres} = {opd, 1'b0};
          cie_pkg::op_logical_right_shift: {sres, scar} = {1'b0, opd};
          cie_pkg::op_rotate_left_carry:   {scar, sres} = {opd, flg_r[`CIE_FLAG_C]};
          cie_pkg::op_rotate_right_carry:  {sres, scar} = {flg_r[`CIE_FLAG_C], opd};
          cie_pkg::op_arithmetic_right_shift: {sres, scar} = {opd[7], opd};
          default: ;
        endcase
      end
    endcase
  end

  // Sequencer, register file and memory requests
  always_comb
  begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    wbk_nxt  = wbk_r;
    wbr_nxt  = wbr_r;
    pc_nxt   = pc_r;
    sp_nxt   = sp_r;
    flg_nxt  = flg_r;
    rf_nxt   = rf_r;
    dreq_nxt = dreq_r;
    dreq_nxt.we = 1'b0;
    dreq_nxt.re = 1'b0;
    io_nxt   = io_r;
    io_nxt.strobe = 1'b0;
    pa_nxt   = pa_r;
    pre_nxt  = 1'b0;
    pwe_nxt  = 1'b0;
    pwd_nxt  = pwd_r;
    slp_nxt  = 1'b0;
    wdk_nxt  = 1'b0;
    dbg_nxt  = rf_r[dbg_raddr];
    unique case (st_r)
      cie_pkg::cie_st_run:
        if (instr_valid)
        begin
          pc_nxt = pc_r + 16'h0001;
          if (is_br)
          begin
            if (br_ok)
            begin
              pc_nxt  = br_tgt;
              st_nxt  = cie_pkg::cie_st_wait;
              cnt_nxt = 2'(`CIE_CYC_BR_TAKEN - 1);
              wbk_nxt = cie_pkg::cie_wb_none;
            end
          end
          else
          begin
            unique case (instr.op)
              cie_pkg::op_register_move:  rf_nxt[instr.rd] = rrv;
              cie_pkg::op_load_immediate: rf_nxt[instr.rd] = instr.imm;
              cie_pkg::op_register_pair_copy:
              begin
                rf_nxt[{instr.rd[4:1], 1'b0}] = rf_r[{instr.rr[4:1], 1'b0}];
                rf_nxt[{instr.rd[4:1], 1'b1}] = rf_r[{instr.rr[4:1], 1'b1}];
              end
              cie_pkg::op_load_indirect, cie_pkg::op_load_displaced,
              cie_pkg::op_store_indirect, cie_pkg::op_store_displaced,
              cie_pkg::op_load_direct, cie_pkg::op_store_direct,
              cie_pkg::op_push, cie_pkg::op_pop:
                // A displaced access through the first pointer is dropped
                if (!(is_disp && instr.ptr == cie_pkg::cie_ptr_x))
                begin
                  st_nxt  = cie_pkg::cie_st_wait;
                  cnt_nxt = 2'(`CIE_CYC_DMEM - 1);
                  wbr_nxt = instr.rd;
                  dreq_nxt.wdata = rrv;
                  dreq_nxt.addr  = ea;
                  dreq_nxt.re = instr.op == cie_pkg::op_load_indirect ||
                                instr.op == cie_pkg::op_load_displaced ||
                                instr.op == cie_pkg::op_load_direct ||
                                instr.op == cie_pkg::op_pop;
                  dreq_nxt.we = !dreq_nxt.re;
                  wbk_nxt = dreq_nxt.re ? cie_pkg::cie_wb_dmem : cie_pkg::cie_wb_none;
                  if (instr.op == cie_pkg::op_load_indirect ||
                      instr.op == cie_pkg::op_store_indirect)
                  begin
                    rf_nxt[pidx]         = np[7:0];
                    rf_nxt[pidx | 5'h01] = np[15:8];
                  end
                  if (instr.op == cie_pkg::op_load_direct ||
                      instr.op == cie_pkg::op_store_direct)
                  begin
                    dreq_nxt.addr = instr.addr;
                    pc_nxt = pc_r + 16'h0002;
                  end
                  if (instr.op == cie_pkg::op_push)
                  begin
                    dreq_nxt.addr = sp_r;
                    sp_nxt = sp_r - 16'h0001;
                  end
                  if (instr.op == cie_pkg::op_pop)
                  begin
                    dreq_nxt.addr = sp_r + 16'h0001;
                    sp_nxt = sp_r + 16'h0001;
                  end
                end
              cie_pkg::op_program_memory_read, cie_pkg::op_extended_program_read:
              begin
                st_nxt  = cie_pkg::cie_st_wait;
                cnt_nxt = 2'(`CIE_CYC_PMEM - 1);
                wbk_nxt = cie_pkg::cie_wb_pmem;
                wbr_nxt = instr.no_operand ? 5'h00 : instr.rd;
                pre_nxt = 1'b1;
                pa_nxt  = {8'h00, zv};
                if (instr.op == cie_pkg::op_extended_program_read)
                  pa_nxt = zext;
                if (instr.pmode == cie_pkg::cie_pm_post_inc)
                begin
                  rf_nxt[`CIE_PTR_Z]         = pa_nxt[7:0] + 8'h01;
                  rf_nxt[`CIE_PTR_Z | 5'h01] = 8'((pa_nxt[15:0] + 16'h0001) >> 8);
                  pwe_nxt = instr.op == cie_pkg::op_extended_program_read;
                  pwd_nxt = 8'((zext + 24'h000001) >> 16);
                end
              end
              cie_pkg::op_io_bit_set, cie_pkg::op_io_bit_clear:
              begin
                st_nxt  = cie_pkg::cie_st_wait;
                cnt_nxt = 2'(`CIE_CYC_IO - 1);
                wbk_nxt = cie_pkg::cie_wb_none;
                io_nxt  = '{addr: instr.imm[4:0], bsel: instr.bsel,
                            value: instr.op == cie_pkg::op_io_bit_set, strobe: 1'b1};
              end
              cie_pkg::op_logical_left_shift, cie_pkg::op_logical_right_shift,
              cie_pkg::op_rotate_left_carry, cie_pkg::op_rotate_right_carry,
              cie_pkg::op_arithmetic_right_shift:
              begin
                rf_nxt[instr.rd]    = sres;
                flg_nxt[`CIE_FLAG_C] = scar;
                flg_nxt[`CIE_FLAG_Z] = sres == 8'h00;
                flg_nxt[`CIE_FLAG_N] = sres[7];
                flg_nxt[`CIE_FLAG_V] = sres[7] ^ scar;
              end
              cie_pkg::op_nibble_swap: rf_nxt[instr.rd] = {opd[3:0], opd[7:4]};
              cie_pkg::op_bit_to_tflag: flg_nxt[`CIE_FLAG_T] = opd[instr.bsel];
              cie_pkg::op_tflag_to_bit: rf_nxt[instr.rd][instr.bsel] = flg_r[`CIE_FLAG_T];
              cie_pkg::op_status_flag_set:   flg_nxt[instr.bsel] = 1'b1;
              cie_pkg::op_status_flag_clear: flg_nxt[instr.bsel] = 1'b0;
              cie_pkg::op_sleep:         slp_nxt = 1'b1;
              cie_pkg::op_watchdog_kick: wdk_nxt = 1'b1;
              cie_pkg::op_break:         st_nxt  = cie_pkg::cie_st_halt;
              default: ;
            endcase
          end
        end
      cie_pkg::cie_st_wait:
        if (cnt_r == 2'h1)
        begin
          st_nxt = cie_pkg::cie_st_run;
          // Load data lands last, so it wins over a pointer update of the same pair
          if (wbk_r == cie_pkg::cie_wb_dmem)
            rf_nxt[wbr_r] = dmem_rdata;
          else if (wbk_r == cie_pkg::cie_wb_pmem)
            rf_nxt[wbr_r] = pmem_rdata;
        end
        else
          cnt_nxt = cnt_r - 2'h1;
      cie_pkg::cie_st_halt:
        if (dbg_resume)
          st_nxt = cie_pkg::cie_st_run;
      default: st_nxt = cie_pkg::cie_st_run;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r  <= cie_pkg::cie_st_run;
      wbk_r <= cie_pkg::cie_wb_none;
      cnt_r <= 2'h0;
      wbr_r <= 5'h00;
      pc_r  <= `CIE_RST_PC;
      sp_r  <= `CIE_RST_SP;
      flg_r <= `CIE_RST_FLAGS;
      rf_r  <= '{default: 8'h00};
      dreq_r <= '0;
      io_r  <= '0;
      pa_r  <= 24'h000000;
      pre_r <= 1'b0;
      pwe_r <= 1'b0;
      pwd_r <= 8'h00;
      slp_r <= 1'b0;
      wdk_r <= 1'b0;
      dbg_r <= 8'h00;
    end
    else
    begin
      st_r  <= st_nxt;
      wbk_r <= wbk_nxt;
      cnt_r <= cnt_nxt;
      wbr_r <= wbr_nxt;
      pc_r  <= pc_nxt;
      sp_r  <= sp_nxt;
      flg_r <= flg_nxt;
      rf_r  <= rf_nxt;
      dreq_r <= dreq_nxt;
      io_r  <= io_nxt;
      pa_r  <= pa_nxt;
      pre_r <= pre_nxt;
      pwe_r <= pwe_nxt;
      pwd_r <= pwd_nxt;
      slp_r <= slp_nxt;
      wdk_r <= wdk_nxt;
      dbg_r <= dbg_nxt;
    end
  end

  assign instr_ready         = st_r == cie_pkg::cie_st_run;
  assign dmem_req            = dreq_r;
  assign io_req              = io_r;
  assign pmem_addr           = pa_r;
  assign pmem_re             = pre_r;
  assign page_ext_we         = pwe_r;
  assign page_ext_wdata      = pwd_r;
  assign sleep_pulse         = slp_r;
  assign watchdog_kick_pulse = wdk_r;
  assign halted              = st_r == cie_pkg::cie_st_halt;
  assign dbg_rdata           = dbg_r;
  assign pc                  = pc_r;
  assign sp                  = sp_r;
  assign status_flags        = flg_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_carry_target;
    acc && instr.op == cie_pkg::op_branch_carry_set && br_ok |=> pc_r == $past(br_tgt);
  endproperty
  a_carry_target: assert property (p_carry_target) else $error("carry branch target wrong");
  property p_signed_ge;
    acc && instr.op == cie_pkg::op_branch_signed_ge && (flg_r[`CIE_FLAG_N] ^ flg_r[`CIE_FLAG_V])
      |=> pc_r == $past(pc_r) + 16'h0001 && instr_ready;
  endproperty
  a_signed_ge: assert property (p_signed_ge) else $error("signed branch taken wrongly");
  property p_neg_flags;
    acc && instr.op == cie_pkg::op_branch_negative |=> flg_r == $past(flg_r);
  endproperty
  a_neg_flags: assert property (p_neg_flags) else $error("branch altered flags");
  property p_taken_two;
    acc && is_br && br_ok |=> !instr_ready ##1 instr_ready;
  endproperty
  a_taken_two: assert property (p_taken_two) else $error("taken branch not two cycles");
  property p_move_one;
    acc && instr.op == cie_pkg::op_register_move
      |=> instr_ready && flg_r == $past(flg_r) && rf_r[$past(instr.rd)] == $past(rrv);
  endproperty
  a_move_one: assert property (p_move_one) else $error("move wrong");
  property p_load_two;
    acc && instr.op == cie_pkg::op_load_indirect |=> !instr_ready && dmem_req.re ##1 instr_ready;
  endproperty
  a_load_two: assert property (p_load_two) else $error("load not two cycles");
  property p_pmem_three;
    acc && instr.op == cie_pkg::op_program_memory_read |=> !instr_ready [*2] ##1 instr_ready;
  endproperty
  a_pmem_three: assert property (p_pmem_three) else $error("program read not three cycles");
  property p_push_sp;
    acc && instr.op == cie_pkg::op_push |=> sp_r == $past(sp_r) - 16'h0001 && dmem_req.we;
  endproperty
  a_push_sp: assert property (p_push_sp) else $error("push stack pointer wrong");
  property p_rol_carry;
    acc && instr.op == cie_pkg::op_rotate_left_carry |=> flg_r[`CIE_FLAG_C] == $past(opd[7]);
  endproperty
  a_rol_carry: assert property (p_rol_carry) else $error("rotate carry wrong");
  property p_swap;
    acc && instr.op == cie_pkg::op_nibble_swap
      |=> rf_r[$past(instr.rd)] == {$past(opd[3:0]), $past(opd[7:4])} && flg_r == $past(flg_r);
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap wrong");
  property p_flag_set;
    acc && instr.op == cie_pkg::op_status_flag_set |=> flg_r[$past(instr.bsel)];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");
  property p_post_inc;
    acc && instr.op == cie_pkg::op_load_indirect && instr.pmode == cie_pkg::cie_pm_post_inc
      && instr.ptr == cie_pkg::cie_ptr_z |=> zv == $past(zv) + 16'h0001;
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("pointer increment wrong");
  c_taken: cover property (acc && is_br && br_ok);
  c_pmem: cover property (acc && instr.op == cie_pkg::op_extended_program_read);
  c_halt: cover property (halted ##1 !halted);
endmodule // cie_core
`default_nettype wire

/* sim/cie_mem_model.sv */
// Purpose: Data memory, program memory and page register beside the core
// Assumes: Data memory decodes only the low address byte
// Notes:   Idle read lines carry a moving pattern, never stale data
`default_nettype none
module cie_mem_model (
  // Clock
  input  wire logic                   clk,
  // Data memory
  input  wire cie_pkg::cie_dmem_req_t dmem_req,
  output logic [7:0]                  dmem_rdata,
  // Program memory and page register
  input  wire logic [23:0]            pmem_addr,
  input  wire logic                   pmem_re,
  output logic [7:0]                  pmem_rdata,
  input  wire logic                   page_ext_we,
  input  wire logic [7:0]             page_ext_wdata,
  output logic [7:0]                  page_ext
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem_r [256];
  logic [7:0] junk_r = 8'h5a;
  logic [7:0] page_r = 8'h00;
  logic [7:0] prd_r = 8'h00;
  always @(posedge clk)
  begin
    junk_r <= junk_r + 8'h37;
    // Answer one cycle after the strobe, junk otherwise
    prd_r <= pmem_re ? (pmem_addr[7:0] ^ pmem_addr[23:16] ^ 8'h3c) : ~junk_r;
    if (dmem_req.we)
      mem_r[dmem_req.addr[7:0]] <= dmem_req.wdata;
    if (page_ext_we)
      page_r <= page_ext_wdata;
  end
  assign pmem_rdata = prd_r;
  assign page_ext   = page_r;
  assign dmem_rdata = dmem_req.re ? mem_r[dmem_req.addr[7:0]] : junk_r;
endmodule // cie_mem_model
`default_nettype wire

/* sim/tb_cpu_instruction_execution.sv */
// Purpose: Self-checking bench for the instruction execution core
// Assumes: Inputs change at the falling clock edge
// Notes:   Table rows first, then pointer, program read and reset by hand
`default_nettype none
module tb_cpu_instruction_execution;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {cie_pkg::cie_op_t op; logic [2:0] bs; logic [7:0] im; logic [6:0] k;
    int cy; logic [15:0] pc; logic [7:0] fl; logic [7:0] rv;} cie_row_t;
  cie_row_t rows [10] = '{
    '{cie_pkg::op_load_immediate, 3'h0, 8'h81, 7'h00, 1, 16'h0001, 8'h00, 8'h81},
    '{cie_pkg::op_status_flag_set, 3'h0, 8'h00, 7'h00, 1, 16'h0002, 8'h01, 8'h81},
    '{cie_pkg::op_branch_carry_set, 3'h0, 8'h00, 7'h03, 2, 16'h0006, 8'h01, 8'h81},
    '{cie_pkg::op_branch_carry_clear, 3'h0, 8'h00, 7'h03, 1, 16'h0007, 8'h01, 8'h81},
    '{cie_pkg::op_rotate_left_carry, 3'h0, 8'h00, 7'h00, 1, 16'h0008, 8'h09, 8'h03},
    '{cie_pkg::op_branch_halfcarry_clear, 3'h0, 8'h00, 7'h7e, 2, 16'h0007, 8'h09, 8'h03},
    '{cie_pkg::op_bit_to_tflag, 3'h1, 8'h00, 7'h00, 1, 16'h0008, 8'h49, 8'h03},
    '{cie_pkg::op_branch_signed_lt, 3'h0, 8'h00, 7'h01, 2, 16'h000a, 8'h49, 8'h03},
    '{cie_pkg::op_nibble_swap, 3'h0, 8'h00, 7'h00, 1, 16'h000b, 8'h49, 8'h30},
    '{cie_pkg::op_branch_signed_ge, 3'h0, 8'h00, 7'h05, 1, 16'h000c, 8'h49, 8'h30}};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic instr_valid = 1'b0;
  logic dbg_resume = 1'b0;
  logic [4:0] dbg_raddr = 5'h00;
  cie_pkg::cie_instr_t instr = '0;
  logic instr_ready, pmem_re, page_ext_we, sleep_pulse, watchdog_kick_pulse, halted;
  logic [7:0] dmem_rdata, pmem_rdata, page_ext, page_ext_wdata, dbg_rdata, status_flags;
  logic [23:0] pmem_addr;
  logic [15:0] pc, sp;
  cie_pkg::cie_dmem_req_t dmem_req;
  cie_pkg::cie_io_req_t io_req;
  int bad_count = 0;
  int cmp_count = 0;
  int pulse_count = 0;
  cie_core uut (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata),
    .pmem_addr(pmem_addr), .pmem_re(pmem_re), .pmem_rdata(pmem_rdata), .page_ext(page_ext),
    .page_ext_we(page_ext_we), .page_ext_wdata(page_ext_wdata), .io_req(io_req),
    .sleep_pulse(sleep_pulse), .watchdog_kick_pulse(watchdog_kick_pulse), .halted(halted),
    .dbg_resume(dbg_resume), .dbg_raddr(dbg_raddr), .dbg_rdata(dbg_rdata), .pc(pc), .sp(sp),
    .status_flags(status_flags));
  cie_mem_model mem (.clk(clk), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata),
    .pmem_addr(pmem_addr), .pmem_re(pmem_re), .pmem_rdata(pmem_rdata),
    .page_ext_we(page_ext_we), .page_ext_wdata(page_ext_wdata), .page_ext(page_ext));
  always #4 clk = ~clk;
  // Counted only out of reset, so power-up unknowns never reach the count
  always @(posedge clk)
    if (rst_b)
      pulse_count <= pulse_count + int'(sleep_pulse) + int'(watchdog_kick_pulse) +
        int'(io_req.strobe);
  function automatic cie_pkg::cie_instr_t mk(cie_pkg::cie_op_t o, logic [4:0] d,
    logic [4:0] r, logic [2:0] b, logic [7:0] m, logic [6:0] kk, cie_pkg::cie_ptr_t pt,
    cie_pkg::cie_pmode_t pm);
    return '{op:o, rd:d, rr:r, bsel:b, ptr:pt, pmode:pm, no_operand:1'b0, imm:m, k:kk,
      addr:16'h0000};
  endfunction
  function automatic cie_pkg::cie_instr_t mkp(cie_pkg::cie_op_t o, logic [4:0] d,
    logic [4:0] r, logic [2:0] b, logic [7:0] m);
    return mk(o, d, r, b, m, 7'h00, cie_pkg::cie_ptr_x, cie_pkg::cie_pm_plain);
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Issue one instruction, count cycles to ready, then check the rd register
  task automatic step(input cie_pkg::cie_instr_t i, input int cy, input logic [15:0] p,
    input logic [7:0] f, input logic [7:0] rv);
    int n;
    instr = i;
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
    n = 1;
    while (instr_ready !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    chk("cycles", 16'(cy), 16'(n));
    chk("pc", p, pc);
    chk("flags", {8'h00, f}, {8'h00, status_flags});
    dbg_raddr = i.rd;
    @(negedge clk);
    chk("register", {8'h00, rv}, {8'h00, dbg_rdata});
    if (n >= 50)
      final_report();
  endtask
  initial
  begin
    cie_row_t r;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    foreach (rows[j])
    begin
      r = rows[j];
      step(mk(r.op, 5'h10, 5'h10, r.bs, r.im, r.k, cie_pkg::cie_ptr_x, cie_pkg::cie_pm_plain),
        r.cy, r.pc, r.fl, r.rv);
    end
    $display("table test done");
    // Pre-decrement from zero must borrow across the pair
    step(mk(cie_pkg::op_store_indirect, 5'h1f, 5'h10, 3'h0, 8'h00, 7'h00, cie_pkg::cie_ptr_z,
      cie_pkg::cie_pm_pre_dec), 2, 16'h000d, 8'h49, 8'hff);
    step(mk(cie_pkg::op_extended_program_read, 5'h12, 5'h00, 3'h0, 8'h00, 7'h00,
      cie_pkg::cie_ptr_z, cie_pkg::cie_pm_post_inc), 3, 16'h000e, 8'h49, 8'hc3);
    chk("page", 16'h0001, {8'h00, page_ext});
    chk("pmem addr", 16'hffff, pmem_addr[15:0]);
    step(mk(cie_pkg::op_load_indirect, 5'h11, 5'h00, 3'h0, 8'h00, 7'h00, cie_pkg::cie_ptr_z,
      cie_pkg::cie_pm_pre_dec), 2, 16'h000f, 8'h49, 8'h30);
    step(mkp(cie_pkg::op_register_move, 5'h14, 5'h12, 3'h0, 8'h00), 1, 16'h0010, 8'h49,
      8'hc3);
    step(mk(cie_pkg::op_load_indirect, 5'h13, 5'h00, 3'h0, 8'h00, 7'h00, cie_pkg::cie_ptr_z,
      cie_pkg::cie_pm_post_inc), 2, 16'h0011, 8'h49, 8'h30);
    step(mkp(cie_pkg::op_push, 5'h12, 5'h12, 3'h0, 8'h00), 2, 16'h0012, 8'h49, 8'hc3);
    chk("sp", 16'h10fe, sp);
    step(mkp(cie_pkg::op_pop, 5'h15, 5'h00, 3'h0, 8'h00), 2, 16'h0013, 8'h49, 8'hc3);
    chk("sp", 16'h10ff, sp);
    chk("dmem addr", 16'h10ff, dmem_req.addr);
    $display("memory test done");
    step(mkp(cie_pkg::op_io_bit_set, 5'h10, 5'h10, 3'h3, 8'h05), 2, 16'h0014, 8'h49,
      8'h30);
    chk("io", 16'h00ae, 16'(io_req));
    step(mkp(cie_pkg::op_sleep, 5'h10, 5'h10, 3'h0, 8'h00), 1, 16'h0015, 8'h49, 8'h30);
    step(mkp(cie_pkg::op_watchdog_kick, 5'h10, 5'h10, 3'h0, 8'h00), 1, 16'h0016, 8'h49,
      8'h30);
    chk("pulses", 16'h0003, 16'(pulse_count));
    instr = mkp(cie_pkg::op_break, 5'h10, 5'h10, 3'h0, 8'h00);
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
    chk("halt ready", 16'h0002, {14'h0000, halted, instr_ready});
    dbg_resume = 1'b1;
    @(negedge clk);
    dbg_resume = 1'b0;
    chk("halt ready", 16'h0001, {14'h0000, halted, instr_ready});
    chk("pc", 16'h0017, pc);
    $display("control test done");
    rst_b = 1'b0;
    @(negedge clk);
    chk("pc", 16'h0000, pc);
    chk("sp", 16'h10ff, sp);
    chk("flags", 16'h0000, {8'h00, status_flags});
    chk("ready", 16'h0001, {15'h0000, instr_ready});
    $display("reset test done");
    final_report();
  end
endmodule // tb_cpu_instruction_execution
`default_nettype wire
